// ---- rtl/rsvm_top.sv ----
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rsvm_top
  import rsvm_pkg::*;
#(
  parameter int unsigned SETTLE_CNT   = SETTLE_CYCLES,
  parameter int unsigned RESTART_OSC  = RELEASE_OSC_COUNT
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [2:0]        cmpAbove,
  input  wire logic              oscTick,
  input  wire logic              wdtUnderflow,
  input  wire logic [7:0]        flashOptionByte,
  output logic                   sysReset_n,
  output logic                   clkDiv8Sel,
  output logic                   monIrq1,
  output logic                   monIrq2,
  output logic                   lowConsumptionEn
);

  rsvm_seq_e   seq_q;
  logic [6:0]  oscCnt_q;
  logic        holdBelow_q;
  logic        opt0Dis_q;
  logic [7:0]  status_q;
  logic [7:0]  enable_q;
  logic [7:0]  l1Ctrl_q;
  logic [7:0]  l2Ctrl_q;
  logic [7:0]  mode0_q;
  logic [7:0]  mode1_q;
  logic [7:0]  protect_q;
  logic        irq1_q;
  logic        irq2_q;

  logic [2:0]  detReady;
  logic [2:0]  detAbove;
  logic [2:0]  detRise;
  logic [2:0]  detFall;
  logic [2:0]  detEn;
  logic [2:0]  detFiltOff;
  logic [5:0]  detSamp;

  logic        wrAck;
  logic        rdAck;
  logic        wrByte;
  logic [7:0]  wrData;
  logic [7:0]  rdByte;
  logic        swResetReq;
  logic        wdtResetReq;
  logic        l0ResetReq;
  logic        l1ResetReq;
  logic        l2ResetReq;
  logic        pwrReset;
  logic        softReset;
  logic        l1Event;
  logic        l2Event;
  logic        l1Flag;
  logic        l2Flag;
  logic        inReset;

  // Detectors: index 0..2 are levels 0..2
  assign detEn      = {enable_q[BIT_L2_DET_EN], enable_q[BIT_L1_DET_EN],
                       enable_q[BIT_L0_DET_EN]};
  assign detFiltOff = {l2Ctrl_q[BIT_CTL_FILT_OFF], l1Ctrl_q[BIT_CTL_FILT_OFF], 1'b1};
  assign detSamp    = {l2Ctrl_q[BIT_CTL_SAMP_LO +: 2], l1Ctrl_q[BIT_CTL_SAMP_LO +: 2],
                       2'b00};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_det
      rsvm_detector #(
        .SETTLE_CNT (SETTLE_CNT)
      ) u_det (
        .clk        (clk),
        .rst_n      (rst_n),
        .detEnable  (detEn[gi]),
        .cmpAbove   (cmpAbove[gi]),
        .oscTick    (oscTick),
        .filterOff  (detFiltOff[gi]),
        .sampleSel  (detSamp[2*gi +: 2]),
        .ready      (detReady[gi]),
        .levelAbove (detAbove[gi]),
        .riseEvt    (detRise[gi]),
        .fallEvt    (detFall[gi])
      );
    end
  endgenerate

  // Bus decode; write or read takes effect when waitrequest is low
  assign wrAck  = avs_write && !avs_waitrequest;
  assign rdAck  = avs_read && !avs_waitrequest;
  assign wrByte = wrAck && avs_byteenable[0];
  assign wrData = avs_writedata[7:0];

  // Monitor flags read 1 when detector disabled or not yet settled
  assign l1Flag = !detReady[1] || detAbove[1];
  assign l2Flag = !detReady[2] || detAbove[2];

  // Reset requests
  assign swResetReq  = wrByte && (avs_address == IDX_PROC_MODE0)
                       && wrData[BIT_SW_RESET];
  assign wdtResetReq = wdtUnderflow && mode1_q[BIT_WDT_RESET_SEL];
  assign l0ResetReq  = detReady[0] && !detAbove[0] && !opt0Dis_q;
  assign l1ResetReq  = detReady[1] && !detAbove[1] && l1Ctrl_q[BIT_CTL_RST_EN]
                       && l1Ctrl_q[BIT_CTL_MODE];
  assign l2ResetReq  = detReady[2] && !detAbove[2] && l2Ctrl_q[BIT_CTL_RST_EN]
                       && l2Ctrl_q[BIT_CTL_MODE];
  assign pwrReset    = (l0ResetReq || l1ResetReq) && (seq_q == RSVM_RUN);
  assign softReset   = (l2ResetReq || wdtResetReq || swResetReq) && (seq_q == RSVM_RUN)
                       && !pwrReset;
  assign inReset     = !rst_n || (seq_q != RSVM_RUN);

  // Interrupt events: filter on = both edges, off = chosen edge
  always_comb begin
    if (!l1Ctrl_q[BIT_CTL_FILT_OFF]) begin
      l1Event = detRise[1] || detFall[1];
    end else begin
      l1Event = l1Ctrl_q[BIT_CTL_COND] ? detFall[1] : detRise[1];
    end
    if (!l2Ctrl_q[BIT_CTL_FILT_OFF]) begin
      l2Event = detRise[2] || detFall[2];
    end else begin
      l2Event = l2Ctrl_q[BIT_CTL_COND] ? detFall[2] : detRise[2];
    end
  end

  // Option strap captured while hardware reset is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opt0Dis_q <= flashOptionByte[BIT_OPT_L0_DISABLE];
    end
  end

  // Reset sequencer; RAM has no clear path from here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_q       <= RSVM_RUN;
      oscCnt_q    <= 7'h00;
      holdBelow_q <= 1'b0;
    end else begin
      case (seq_q)
        RSVM_RUN: begin
          oscCnt_q <= 7'h00;
          if (pwrReset) begin
            seq_q       <= RSVM_HOLD;
            holdBelow_q <= 1'b1;
          end else if (softReset) begin
            seq_q       <= RSVM_COUNT;
            holdBelow_q <= 1'b0;
          end
        end
        RSVM_HOLD: begin
          oscCnt_q <= 7'h00;
          if (l0ResetReq || l1ResetReq) begin
            seq_q <= RSVM_HOLD;
          end else begin
            seq_q <= RSVM_COUNT;
          end
        end
        RSVM_COUNT: begin
          if (holdBelow_q && (l0ResetReq || l1ResetReq)) begin
            seq_q    <= RSVM_HOLD;
            oscCnt_q <= 7'h00;
          end else if (oscTick) begin
            if (holdBelow_q && oscCnt_q == 7'(RELEASE_OSC_COUNT - 1)) begin
              seq_q <= RSVM_RUN;
            end else if (!holdBelow_q && oscCnt_q == 7'(RESTART_OSC - 1)) begin
              seq_q <= RSVM_RUN;
            end
            oscCnt_q <= oscCnt_q + 7'h01;
          end
        end
        default: begin
          seq_q <= RSVM_RUN;
        end
      endcase
    end
  end

  // Single merged reset and clock selection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysReset_n <= 1'b0;
      clkDiv8Sel <= 1'b1;
    end else begin
      sysReset_n <= (seq_q == RSVM_RUN) && !pwrReset && !softReset;
      // Stays high one cycle past reset release
      clkDiv8Sel <= inReset || pwrReset || softReset || !sysReset_n;
    end
  end

  // Processor mode and protect registers reset on every source
  always_ff @(posedge clk) begin
    if (inReset) begin
      mode0_q   <= BYTE_ZERO;
      mode1_q   <= BYTE_ZERO;
      protect_q <= BYTE_ZERO;
    end else if (wrByte) begin
      if (avs_address == IDX_PROC_MODE1) begin
        mode1_q <= wrData;
      end
      if (avs_address == IDX_PROTECT) begin
        protect_q <= wrData;
      end
      if (avs_address == IDX_PROC_MODE0) begin
        mode0_q <= wrData & ~(8'h01 << BIT_SW_RESET);
      end
    end
  end

  // Status and enable: only hardware, level-0 and level-1 resets reinitialise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
      enable_q <= flashOptionByte[BIT_OPT_L0_DISABLE] ? ENABLE_RST_OFF
                                                      : ENABLE_RST_ON;
    end else if (pwrReset) begin
      status_q <= STATUS_RST;
      // Level-1 detector stays on so its recovery can end the hold
      enable_q <= ENABLE_RST_ON | (enable_q & (8'h01 << BIT_L1_DET_EN));
    end else if (wrByte && !inReset) begin
      if (avs_address == IDX_STATUS) begin
        status_q <= wrData & STATUS_WR_MASK;
      end
      if (avs_address == IDX_ENABLE) begin
        enable_q <= wrData & ENABLE_WR_MASK;
      end
    end
  end

  assign lowConsumptionEn = enable_q[BIT_LOW_CONSUMPTION];

  // Level-1 control; software/watchdog/level-2 resets leave it alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      l1Ctrl_q <= flashOptionByte[BIT_OPT_L1_DISABLE] ? L1CTRL_RST_OFF
                                                      : L1CTRL_RST_ON;
    end else if (l1ResetReq && (seq_q == RSVM_RUN)) begin
      l1Ctrl_q <= L1CTRL_RST_ON;
    end else begin
      if (wrByte && !inReset && avs_address == IDX_LEVEL1_CTRL
          && protect_q[BIT_MON_UNPROTECT]) begin
        l1Ctrl_q <= (wrData & CTRL_WR_MASK) | (l1Ctrl_q & ~CTRL_WR_MASK & wrData);
      end
      if (l1Event && detEn[1]) begin
        l1Ctrl_q[BIT_CTL_CHANGE] <= 1'b1;
      end
    end
  end

  // Level-2 control: change flag and watchdog flag persist over soft resets
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      l2Ctrl_q <= L2CTRL_RST;
    end else if (pwrReset) begin
      l2Ctrl_q <= L2CTRL_RST;
    end else begin
      if (wrByte && !inReset && avs_address == IDX_LEVEL2_CTRL
          && protect_q[BIT_MON_UNPROTECT]) begin
        l2Ctrl_q <= (wrData & CTRL_WR_MASK) | (l2Ctrl_q & ~CTRL_WR_MASK & wrData);
      end
      if (l2Event && detEn[2]) begin
        l2Ctrl_q[BIT_CTL_CHANGE] <= 1'b1;
      end
      if (wdtUnderflow) begin
        l2Ctrl_q[BIT_CTL_FLAG3] <= 1'b1;
      end
    end
  end

  // Interrupt pulses in interrupt mode only
  always_ff @(posedge clk) begin
    if (inReset) begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      irq1_q <= l1Event && l1Ctrl_q[BIT_CTL_RST_EN]
                && !l1Ctrl_q[BIT_CTL_MODE];
      irq2_q <= l2Event && l2Ctrl_q[BIT_CTL_RST_EN]
                && !l2Ctrl_q[BIT_CTL_MODE];
    end
  end

  assign monIrq1 = irq1_q;
  assign monIrq2 = irq2_q;

  // Read multiplexer
  always_comb begin
    case (avs_address)
      IDX_PROC_MODE0:  rdByte = mode0_q;
      IDX_PROC_MODE1:  rdByte = mode1_q;
      IDX_PROTECT:     rdByte = protect_q;
      IDX_STATUS: begin
        rdByte                  = status_q;
        rdByte[BIT_L2_MON_FLAG] = l2Flag;
      end
      IDX_ENABLE:      rdByte = enable_q;
      IDX_LEVEL1_CTRL: begin
        rdByte                = l1Ctrl_q;
        rdByte[BIT_CTL_FLAG3] = l1Flag;
      end
      IDX_LEVEL2_CTRL: rdByte = l2Ctrl_q;
      default:         rdByte = BYTE_ZERO;
    endcase
  end

  // One wait state per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h000000, rdByte};
      end
    end
  end

endmodule // rsvm_top
`default_nettype wire

// ---- rtl/rsvm_pkg.sv ----
package rsvm_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W                = 6;
  localparam logic [5:0] IDX_PROC_MODE0         = 6'h04;
  localparam logic [5:0] IDX_PROC_MODE1         = 6'h05;
  localparam logic [5:0] IDX_PROTECT            = 6'h0A;
  localparam logic [5:0] IDX_STATUS             = 6'h31;
  localparam logic [5:0] IDX_ENABLE             = 6'h32;
  localparam logic [5:0] IDX_LEVEL1_CTRL        = 6'h36;
  localparam logic [5:0] IDX_LEVEL2_CTRL        = 6'h37;

  // Field positions
  localparam int unsigned BIT_SW_RESET          = 3;  // processor_mode_reg0
  localparam int unsigned BIT_WDT_RESET_SEL     = 2;  // processor_mode_reg1
  localparam int unsigned BIT_MON_UNPROTECT     = 3;  // protect register
  localparam int unsigned BIT_L2_MON_FLAG       = 3;  // status
  localparam int unsigned BIT_LOW_CONSUMPTION   = 0;  // enable
  localparam int unsigned BIT_L0_DET_EN         = 5;
  localparam int unsigned BIT_L1_DET_EN         = 6;
  localparam int unsigned BIT_L2_DET_EN         = 7;
  localparam int unsigned BIT_OPT_L0_DISABLE    = 5;  // flash option byte
  localparam int unsigned BIT_OPT_L1_DISABLE    = 6;
  // Monitor control layout
  localparam int unsigned BIT_CTL_RST_EN        = 0;
  localparam int unsigned BIT_CTL_FILT_OFF      = 1;
  localparam int unsigned BIT_CTL_CHANGE        = 2;
  localparam int unsigned BIT_CTL_FLAG3         = 3;
  localparam int unsigned BIT_CTL_SAMP_LO       = 4;
  localparam int unsigned BIT_CTL_MODE          = 6;
  localparam int unsigned BIT_CTL_COND          = 7;

  // Reset values
  localparam logic [7:0] STATUS_RST             = 8'h08;
  localparam logic [7:0] STATUS_WR_MASK         = 8'hF7;
  localparam logic [7:0] ENABLE_RST_OFF         = 8'h00;
  localparam logic [7:0] ENABLE_RST_ON          = 8'h20;
  localparam logic [7:0] ENABLE_WR_MASK         = 8'hE1;
  localparam logic [7:0] L1CTRL_RST_OFF         = 8'h00;
  localparam logic [7:0] L1CTRL_RST_ON          = 8'h41;
  localparam logic [7:0] L2CTRL_RST             = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK           = 8'hF3;
  localparam logic [7:0] BYTE_ZERO              = 8'h00;

  // Timing
  localparam int unsigned CLK_MHZ               = 125;
  localparam int unsigned RELEASE_OSC_COUNT     = 32;
  localparam int unsigned FILTER_SAMPLE_MULT    = 4;
  localparam int unsigned SETTLE_TIME_US        = 100;
  localparam int unsigned SETTLE_CYCLES         = SETTLE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    RSVM_RUN,
    RSVM_HOLD,
    RSVM_COUNT
  } rsvm_seq_e;

endpackage

// ---- rtl/rsvm_detector.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsvm_detector
  import rsvm_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       detEnable,
  input  wire logic       cmpAbove,
  input  wire logic       oscTick,
  input  wire logic       filterOff,
  input  wire logic [1:0] sampleSel,
  output logic            ready,
  output logic            levelAbove,
  output logic            riseEvt,
  output logic            fallEvt
);

  logic        syncA_q;
  logic        syncB_q;
  logic [23:0] settle_q;
  logic [5:0]  divCnt_q;
  logic        sampPrev_q;
  logic        filt_q;
  logic        lvl_q;
  logic [5:0]  divLast;
  logic        lvlNext;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
    end else begin
      syncA_q <= cmpAbove;
      syncB_q <= syncA_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !detEnable) begin
      settle_q <= 24'h000000;
      ready    <= 1'b0;
    end else if (!ready) begin
      if (settle_q >= 24'(SETTLE_CNT - 1)) begin
        ready <= 1'b1;
      end
      settle_q <= settle_q + 24'h000001;
    end
  end

  // Sample period is four times the divided oscillator period
  assign divLast = 6'((FILTER_SAMPLE_MULT << sampleSel) - 1);

  always_ff @(posedge clk) begin
    if (!rst_n || !ready) begin
      divCnt_q   <= 6'h00;
      sampPrev_q <= 1'b1;
      filt_q     <= 1'b1;
    end else if (oscTick) begin
      if (divCnt_q >= divLast) begin
        divCnt_q   <= 6'h00;
        sampPrev_q <= syncB_q;
        if (sampPrev_q == syncB_q) begin
          filt_q <= syncB_q;
        end
      end else begin
        divCnt_q <= divCnt_q + 6'h01;
      end
    end
  end

  // Disabled or settling detectors read as above threshold
  assign lvlNext = !ready ? 1'b1 : (filterOff ? syncB_q : filt_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q   <= 1'b1;
      riseEvt <= 1'b0;
      fallEvt <= 1'b0;
    end else begin
      lvl_q   <= lvlNext;
      riseEvt <= ready && lvlNext && !lvl_q;
      fallEvt <= ready && !lvlNext && lvl_q;
    end
  end

  assign levelAbove = lvl_q;

endmodule // rsvm_detector
`default_nettype wire

// ---- testbench/rsvm_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsvm_props
  import rsvm_pkg::*;
#(
  parameter int unsigned SETTLE_CNT  = SETTLE_CYCLES,
  parameter int unsigned RESTART_OSC = RELEASE_OSC_COUNT
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [2:0]        cmpAbove,
  input wire logic              oscTick,
  input wire logic              wdtUnderflow,
  input wire logic [7:0]        flashOptionByte,
  input wire logic              sysReset_n,
  input wire logic              clkDiv8Sel,
  input wire logic              monIrq1,
  input wire logic              monIrq2,
  input wire logic              lowConsumptionEn
);
  logic [7:0] tickCnt_q;
  logic [7:0] hiCnt_q;
  logic       armed_q;
  // Ticks seen while the merged reset is low
  always_ff @(posedge clk) begin
    if (!rst_n || sysReset_n) tickCnt_q <= 8'h00;
    else if (oscTick && tickCnt_q != 8'hFF) tickCnt_q <= tickCnt_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !cmpAbove[2]) hiCnt_q <= 8'h00;
    else if (hiCnt_q != 8'hFF) hiCnt_q <= hiCnt_q + 8'h01;
  end
  // Skips the release that follows a hardware reset
  always_ff @(posedge clk) begin
    if (!rst_n) armed_q <= 1'b0;
    else if (sysReset_n) armed_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence swAck_s;
    avs_write && !avs_waitrequest && avs_byteenable[0] && sysReset_n &&
      avs_address == IDX_PROC_MODE0 && avs_writedata[BIT_SW_RESET];
  endsequence
  sequence relEdge_s;
    armed_q && $rose(sysReset_n);
  endsequence
  AST_SW_RESET: assert property (swAck_s |=> !sysReset_n [*8] ##[1:400] sysReset_n)
    else $error("software reset not applied and released");
  AST_SW_CLKSEL: assert property (swAck_s |=> clkDiv8Sel [*8])
    else $error("divide-by-8 clock not held after software reset");
  AST_CLK_IN_RESET: assert property (!sysReset_n |-> clkDiv8Sel)
    else $error("clock select dropped during reset");
  AST_CLK_AFTER: assert property (relEdge_s |-> clkDiv8Sel ##1 (!clkDiv8Sel || !sysReset_n))
    else $error("clock select wrong around reset release");
  AST_CLK_ONLY_RESET: assert property ($rose(clkDiv8Sel) |-> !sysReset_n)
    else $error("clock select raised outside reset");
  AST_RELEASE_COUNT: assert property (relEdge_s |-> tickCnt_q >= RESTART_OSC)
    else $error("reset released before the oscillator count");
  AST_IRQ2_PULSE: assert property (monIrq2 |=> !monIrq2)
    else $error("monitor interrupt longer than one cycle");
  AST_STATUS_FLAG: assert property (avs_read && !avs_waitrequest && avs_address == IDX_STATUS &&
      hiCnt_q == 8'hFF |-> avs_readdata[BIT_L2_MON_FLAG])
    else $error("level-2 flag low while supply above threshold");
endmodule // rsvm_props
bind rsvm_top rsvm_props #(.SETTLE_CNT(SETTLE_CNT), .RESTART_OSC(RESTART_OSC)) u_rsvm_props (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmpAbove(cmpAbove),
  .oscTick(oscTick), .wdtUnderflow(wdtUnderflow), .flashOptionByte(flashOptionByte),
  .sysReset_n(sysReset_n), .clkDiv8Sel(clkDiv8Sel), .monIrq1(monIrq1), .monIrq2(monIrq2),
  .lowConsumptionEn(lowConsumptionEn));
`default_nettype wire

// ---- testbench/test_rsvm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rsvm_top
  import rsvm_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, oscTick = 1'b0;
  logic wdtUnderflow = 1'b0, avs_waitrequest, sysReset_n, clkDiv8Sel, monIrq1, monIrq2, lowCons;
  logic [ADDR_W-1:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic [2:0] cmpAbove = 3'h7;
  logic [7:0] flashOptionByte = 8'h00, q, lowTicks = 8'h00;
  logic [1:0] div = 2'h0;
  int errors = 0, comparisons = 0, t0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    div <= div + 2'h1;
    oscTick <= (div == 2'h3);
    lowTicks <= sysReset_n ? 8'h00 : lowTicks + {7'h00, oscTick};
  end
  rsvm_top #(.SETTLE_CNT(8), .RESTART_OSC(32)) u_rsvm_top (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmpAbove(cmpAbove), .oscTick(oscTick),
    .wdtUnderflow(wdtUnderflow), .flashOptionByte(flashOptionByte), .sysReset_n(sysReset_n),
    .clkDiv8Sel(clkDiv8Sel), .monIrq1(monIrq1), .monIrq2(monIrq2), .lowConsumptionEn(lowCons));
  task automatic final_report();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) chk(32'h1, 32'h0);
    if (n >= 100) final_report();
    @(posedge clk);
  endtask
  // Waits for sysReset_n (s=0), monIrq2 (s=1) or monIrq1 (s=2) to reach v
  task automatic waitLvl(input int s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s == 0 ? sysReset_n : (s == 1 ? monIrq2 : monIrq1)) !== v && n < lim);
    if (n >= lim) chk({31'h0, ~v}, {31'h0, v});
    if (n >= lim) final_report();
  endtask
  task automatic hwReset(input logic [7:0] opt);
    flashOptionByte <= opt;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic t_regs();
    bus(1, IDX_LEVEL1_CTRL, 8'h00);
    bus(0, IDX_LEVEL1_CTRL, 8'h00); chk(q, L1CTRL_RST_ON | (8'h01 << BIT_CTL_FLAG3));
    bus(0, IDX_STATUS, 8'h00); chk(q, STATUS_RST);
    bus(0, IDX_ENABLE, 8'h00); chk(q, ENABLE_RST_ON);
    bus(0, 6'h3F, 8'h00); chk(q, BYTE_ZERO);
    $display("test regs done");
  endtask
  task automatic t_swreset();
    bus(1, IDX_ENABLE, 8'h21);
    chk(lowCons, 1'b1);
    bus(1, IDX_PROC_MODE0, 8'h08);
    chk(sysReset_n, 1'b0);
    chk(clkDiv8Sel, 1'b1);
    waitLvl(0, 1, 600);
    chk(lowTicks >= 8'd32 && lowTicks <= 8'd33, 1'b1);
    @(posedge clk);
    bus(0, IDX_ENABLE, 8'h00); chk(q, 8'h21);
    $display("test swreset done");
  endtask
  task automatic t_wdt();
    wdtUnderflow <= 1'b1;
    @(posedge clk);
    wdtUnderflow <= 1'b0;
    repeat (10) @(posedge clk);
    chk(sysReset_n, 1'b1);
    bus(1, IDX_PROC_MODE1, 8'h04);
    wdtUnderflow <= 1'b1;
    @(posedge clk);
    wdtUnderflow <= 1'b0;
    waitLvl(0, 0, 10);
    waitLvl(0, 1, 600);
    @(posedge clk);
    $display("test wdt done");
  endtask
  task automatic t_level2();
    bus(1, IDX_PROTECT, 8'h08);
    bus(1, IDX_LEVEL2_CTRL, 8'h01);
    bus(1, IDX_ENABLE, 8'hA0);
    repeat (40) @(posedge clk);
    cmpAbove[2] <= 1'b0;
    waitLvl(1, 1, 400);
    bus(0, IDX_STATUS, 8'h00); chk(q, 8'h00);
    cmpAbove[2] <= 1'b1;
    waitLvl(1, 1, 400);
    bus(1, IDX_PROTECT, 8'h08);
    bus(1, IDX_LEVEL2_CTRL, 8'h03);
    cmpAbove[2] <= 1'b0;
    t0 = 0;
    repeat (200) begin
      @(posedge clk);
      t0 += monIrq2;
    end
    chk(t0, 0);
    cmpAbove[2] <= 1'b1;
    waitLvl(1, 1, 400);
    bus(1, IDX_ENABLE, 8'h20);
    cmpAbove[2] <= 1'b0;
    repeat (40) @(posedge clk);
    bus(0, IDX_STATUS, 8'h00); chk(q, STATUS_RST);
    cmpAbove[2] <= 1'b1;
    $display("test level2 done");
  endtask
  task automatic t_level1();
    bus(1, IDX_ENABLE, 8'h60);
    repeat (40) @(posedge clk);
    bus(1, IDX_PROTECT, 8'h08);
    bus(1, IDX_LEVEL1_CTRL, 8'h01);
    cmpAbove[1] <= 1'b0;
    waitLvl(2, 1, 400);
    cmpAbove[1] <= 1'b1;
    waitLvl(2, 1, 400);
    bus(1, IDX_PROTECT, 8'h08);
    bus(1, IDX_LEVEL1_CTRL, 8'h41);
    cmpAbove[1] <= 1'b0;
    waitLvl(0, 0, 400);
    repeat (200) @(posedge clk);
    chk(sysReset_n, 1'b0);
    t0 = lowTicks;
    cmpAbove[1] <= 1'b1;
    waitLvl(0, 1, 800);
    chk(lowTicks - t0 >= 32, 1'b1);
    @(posedge clk);
    bus(0, IDX_ENABLE, 8'h00); chk(q, ENABLE_RST_ON | (8'h01 << BIT_L1_DET_EN));
    $display("test level1 done");
  endtask
  task automatic t_optoff();
    hwReset(8'h60);
    repeat (300) @(posedge clk);
    bus(0, IDX_ENABLE, 8'h00); chk(q, ENABLE_RST_OFF);
    bus(0, IDX_LEVEL1_CTRL, 8'h00); chk(q, L1CTRL_RST_OFF | (8'h01 << BIT_CTL_FLAG3));
    bus(0, IDX_STATUS, 8'h00); chk(q, STATUS_RST);
    $display("test optoff done");
  endtask
  initial begin
    hwReset(8'h00);
    t_regs();
    t_swreset();
    t_wdt();
    t_level2();
    t_level1();
    t_optoff();
    final_report();
  end
endmodule // test_rsvm_top
`default_nettype wire
